// ==== cca_pkg.sv ====
// cca_pkg: register map, field layouts, limits and divider counts of the calendar clock.
// assumes an 8-bit i/o data bus with 16-bit addresses and a single 125 MHz core clock.
package cca_pkg;

  // register addresses on the i/o bus
  localparam logic [15:0] CCA_ADDR_SEC  = 16'h00E0;
  localparam logic [15:0] CCA_ADDR_MIN  = 16'h00E1;
  localparam logic [15:0] CCA_ADDR_HRS  = 16'h00E2;
  localparam logic [15:0] CCA_ADDR_DOW  = 16'h00E3;
  localparam logic [15:0] CCA_ADDR_DOM  = 16'h00E4;
  localparam logic [15:0] CCA_ADDR_MON  = 16'h00E5;
  localparam logic [15:0] CCA_ADDR_YR   = 16'h00E6;
  localparam logic [15:0] CCA_ADDR_CEN  = 16'h00E7;
  localparam logic [15:0] CCA_ADDR_ASEC = 16'h00E8;
  localparam logic [15:0] CCA_ADDR_AMIN = 16'h00E9;
  localparam logic [15:0] CCA_ADDR_AHRS = 16'h00EA;
  localparam logic [15:0] CCA_ADDR_ADOW = 16'h00EB;
  localparam logic [15:0] CCA_ADDR_AEN  = 16'h00EC;
  localparam logic [15:0] CCA_ADDR_CTRL = 16'h00ED;

  // field limits, held as binary values
  localparam logic [7:0] CCA_ZERO      = 8'h00;
  localparam logic [7:0] CCA_ONE       = 8'h01;
  localparam logic [7:0] CCA_TEN       = 8'h0A;
  localparam logic [7:0] CCA_SEC_MAX   = 8'h3B;
  localparam logic [7:0] CCA_MIN_MAX   = 8'h3B;
  localparam logic [7:0] CCA_HRS_MAX   = 8'h17;
  localparam logic [7:0] CCA_DOW_MAX   = 8'h07;
  localparam logic [7:0] CCA_MON_MAX   = 8'h0C;
  localparam logic [7:0] CCA_YR_MAX    = 8'h63;
  localparam logic [7:0] CCA_CEN_MAX   = 8'h63;
  localparam logic [7:0] CCA_DAYS_LONG = 8'h1F;
  localparam logic [7:0] CCA_DAYS_SHRT = 8'h1E;
  localparam logic [7:0] CCA_DAYS_FEB  = 8'h1C;
  localparam logic [7:0] CCA_DAYS_LEAP = 8'h1D;
  localparam logic [7:0] CCA_MON_FEB   = 8'h02;
  localparam logic [7:0] CCA_MON_APR   = 8'h04;
  localparam logic [7:0] CCA_MON_JUN   = 8'h06;
  localparam logic [7:0] CCA_MON_SEP   = 8'h09;
  localparam logic [7:0] CCA_MON_NOV   = 8'h0B;
  localparam logic [1:0] CCA_LEAP_LOW  = 2'h0;
  localparam logic [3:0] CCA_NIB_ZERO  = 4'h0;

  // source edges per second
  localparam logic [15:0] CCA_DIV_OSC = 16'h8000;
  localparam logic [15:0] CCA_DIV_50  = 16'h0032;
  localparam logic [15:0] CCA_DIV_60  = 16'h003C;

  typedef enum logic
  {
    CCA_SRC_OSC  = 1'b0,
    CCA_SRC_LINE = 1'b1
  } cca_src_e;

  typedef struct packed
  {
    logic       alarm_flag;
    logic       alarm_irq_enable;
    logic       decimal_format_enable;
    logic       count_source_select;
    logic       line_freq_60;
    logic [1:0] rsvd;
    logic       count_write_unlock;
  } cca_ctrl_s;

  typedef struct packed
  {
    logic [3:0] rsvd;
    logic       dow;
    logic       hrs;
    logic       min;
    logic       sec;
  } cca_alarm_en_s;

  typedef struct packed
  {
    logic [7:0] cen;
    logic [7:0] yr;
    logic [7:0] mon;
    logic [7:0] dom;
    logic [7:0] dow;
    logic [7:0] hrs;
    logic [7:0] min;
    logic [7:0] sec;
  } cca_time_s;

  localparam cca_ctrl_s     CCA_CTRL_RESET = 8'h00;
  localparam cca_alarm_en_s CCA_AEN_RESET  = 8'h00;

endpackage

// ==== cca_div.sv ====
// cca_div: one-second tick divider counting edges of the selected source.
// assumes src_edge is a one-cycle pulse already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module cca_div
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        run,
  input  wire logic        src_edge,
  input  wire logic [15:0] limit,
  output var  logic        tick
);

  logic [15:0] cnt_q;
  logic        tick_q;

  // clear restarts from a fresh phase
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
    end
    else if (clr)
    begin
      cnt_q <= 16'h0000;
    end
    else if (run && src_edge)
    begin
      if (cnt_q >= 16'(limit - 16'h0001))
      begin
        cnt_q <= 16'h0000;
      end
      else
      begin
        cnt_q <= 16'(cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= !clr && run && src_edge && (cnt_q >= 16'(limit - 16'h0001));
    end
  end

  assign tick = tick_q;

endmodule // cca_div
`default_nettype wire

// ==== cca_top.sv ====
// cca_top: calendar clock with alarm, reached by i/o read and write strobes.
// assumes the strobes are one-cycle pulses on mclk; the source pins are asynchronous.
// Behaviour
// - count seconds through century, 24-hour hours
// - one shared binary or decimal format
// - leap years only in decimal format
// - four alarm set-points, each separately enabled
// - alarm when all enabled fields match
// - interrupt when alarm and irq enable
// - control read clears flag and interrupt
// - alarm registers writable regardless of lock
// - compare alarms on every one-second increment
// - writing unlock zero forces a comparison
// - divider makes tick from oscillator or line
// - source chosen in control; write resets divider
// - reset clears every alarm enable
// - clearing unlock resets and restarts divider
// - unlocked stops count, allows count writes
// - reset leaves the clock locked
// - seconds count survives reset
// - decimal enable picks decimal, else binary
// - decimal seconds: tens 7:4, ones 3:0
// - binary seconds hold zero to fifty-nine
// - decimal minutes tens 0-5, ones 0-9
// - decimal hours tens digit 0-2
// - weekday counts one to seven
// - binary month holds one to twelve
`timescale 1ns/1ps
`default_nettype none
module cca_top
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata,
  input  wire logic        osc32k_pin,
  input  wire logic        crystal_out_pin,
  output var  logic        irq
);

  cca_pkg::cca_time_s     time_q;
  cca_pkg::cca_time_s     time_d;
  cca_pkg::cca_time_s     alarm_q;
  cca_pkg::cca_alarm_en_s aen_q;
  cca_pkg::cca_ctrl_s     ctrl_q;
  logic [7:0]             rdata_q;
  logic                   irq_q;
  logic                   flag_q;
  logic                   cmp_pend_q;
  logic [2:0]             osc_sync_q;
  logic [2:0]             line_sync_q;
  logic                   src_edge;
  logic [15:0]            div_limit;
  logic                   tick;
  logic                   bcd;
  logic                   unlocked;
  logic                   wr_ctrl;
  logic                   rd_ctrl;
  logic                   cmp_force;
  logic                   match_hit;
  logic                   any_en;

  // value of a field in plain binary
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic dec);
    if (dec)
    begin
      return 8'({4'h0, v[7:4]} * cca_pkg::CCA_TEN + {4'h0, v[3:0]});
    end
    return v;
  endfunction

  // binary value back into the current format
  function automatic logic [7:0] from_bin(input logic [7:0] b, input logic dec);
    if (dec)
    begin
      return {4'(b / cca_pkg::CCA_TEN), 4'(b % cca_pkg::CCA_TEN)};
    end
    return b;
  endfunction

  // a field at or past its top wraps; out-of-range values recover the same way
  function automatic logic at_top(input logic [7:0] v, input logic [7:0] hi, input logic dec);
    return to_bin(v, dec) >= hi;
  endfunction

  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi, input logic dec);
    if (at_top(v, hi, dec))
    begin
      return from_bin(lo, dec);
    end
    return from_bin(8'(to_bin(v, dec) + cca_pkg::CCA_ONE), dec);
  endfunction

  // month length; binary format keeps february at 28 days
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr,
                                         input logic [7:0] cen, input logic dec);
    logic [7:0] m;
    logic [7:0] y;
    logic [7:0] c;
    logic       leap;
    m = to_bin(mon, dec);
    y = to_bin(yr, dec);
    c = to_bin(cen, dec);
    leap = dec && (y[1:0] == cca_pkg::CCA_LEAP_LOW)
           && ((y != cca_pkg::CCA_ZERO) || (c[1:0] == cca_pkg::CCA_LEAP_LOW));
    if (m == cca_pkg::CCA_MON_FEB)
    begin
      return leap ? cca_pkg::CCA_DAYS_LEAP : cca_pkg::CCA_DAYS_FEB;
    end
    else if ((m == cca_pkg::CCA_MON_APR) || (m == cca_pkg::CCA_MON_JUN) ||
             (m == cca_pkg::CCA_MON_SEP) || (m == cca_pkg::CCA_MON_NOV))
    begin
      return cca_pkg::CCA_DAYS_SHRT;
    end
    return cca_pkg::CCA_DAYS_LONG;
  endfunction

  assign bcd       = ctrl_q.decimal_format_enable;
  assign unlocked  = ctrl_q.count_write_unlock;
  assign wr_ctrl   = io_wr && (io_addr == cca_pkg::CCA_ADDR_CTRL);
  assign rd_ctrl   = io_rd && (io_addr == cca_pkg::CCA_ADDR_CTRL);
  assign cmp_force = wr_ctrl && !io_wdata[0];

  // two flops before use, third flop only feeds the edge detector
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      osc_sync_q  <= 3'h0;
      line_sync_q <= 3'h0;
    end
    else
    begin
      osc_sync_q  <= {osc_sync_q[1:0], osc32k_pin};
      line_sync_q <= {line_sync_q[1:0], crystal_out_pin};
    end
  end

  always_comb
  begin
    if (cca_pkg::cca_src_e'(ctrl_q.count_source_select) == cca_pkg::CCA_SRC_LINE)
    begin
      src_edge  = line_sync_q[1] && !line_sync_q[2];
      div_limit = ctrl_q.line_freq_60 ? cca_pkg::CCA_DIV_60 : cca_pkg::CCA_DIV_50;
    end
    else
    begin
      src_edge  = osc_sync_q[1] && !osc_sync_q[2];
      div_limit = cca_pkg::CCA_DIV_OSC;
    end
  end

  cca_div u_div
  (
    .mclk     (mclk),
    .rst      (rst),
    .clr      (wr_ctrl),
    .run      (!unlocked),
    .src_edge (src_edge),
    .limit    (div_limit),
    .tick     (tick)
  );

  // count cascade, or a software load while unlocked
  always_comb
  begin
    time_d = time_q;
    if (tick && !unlocked)
    begin
      time_d.sec = step(time_q.sec, cca_pkg::CCA_ZERO, cca_pkg::CCA_SEC_MAX, bcd);
      if (at_top(time_q.sec, cca_pkg::CCA_SEC_MAX, bcd))
      begin
        time_d.min = step(time_q.min, cca_pkg::CCA_ZERO, cca_pkg::CCA_MIN_MAX, bcd);
        if (at_top(time_q.min, cca_pkg::CCA_MIN_MAX, bcd))
        begin
          time_d.hrs = step(time_q.hrs, cca_pkg::CCA_ZERO, cca_pkg::CCA_HRS_MAX, bcd);
          if (at_top(time_q.hrs, cca_pkg::CCA_HRS_MAX, bcd))
          begin
            time_d.dow = step(time_q.dow, cca_pkg::CCA_ONE, cca_pkg::CCA_DOW_MAX, bcd);
            time_d.dom = step(time_q.dom, cca_pkg::CCA_ONE,
                              days_in(time_q.mon, time_q.yr, time_q.cen, bcd), bcd);
            if (at_top(time_q.dom, days_in(time_q.mon, time_q.yr, time_q.cen, bcd), bcd))
            begin
              time_d.mon = step(time_q.mon, cca_pkg::CCA_ONE, cca_pkg::CCA_MON_MAX, bcd);
              if (at_top(time_q.mon, cca_pkg::CCA_MON_MAX, bcd))
              begin
                time_d.yr = step(time_q.yr, cca_pkg::CCA_ZERO, cca_pkg::CCA_YR_MAX, bcd);
                if (at_top(time_q.yr, cca_pkg::CCA_YR_MAX, bcd))
                begin
                  time_d.cen = step(time_q.cen, cca_pkg::CCA_ZERO, cca_pkg::CCA_CEN_MAX, bcd);
                end
              end
            end
          end
        end
      end
    end
    else if (io_wr && unlocked)
    begin
      if (io_addr == cca_pkg::CCA_ADDR_SEC)
      begin
        time_d.sec = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_MIN)
      begin
        time_d.min = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_HRS)
      begin
        time_d.hrs = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_DOW)
      begin
        time_d.dow = {cca_pkg::CCA_NIB_ZERO, io_wdata[3:0]};
      end
      else if (io_addr == cca_pkg::CCA_ADDR_DOM)
      begin
        time_d.dom = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_MON)
      begin
        time_d.mon = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_YR)
      begin
        time_d.yr = io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_CEN)
      begin
        time_d.cen = io_wdata;
      end
    end
  end

  // no reset: the time must outlive a reset of the core
  always_ff @(posedge mclk)
  begin
    time_q <= time_d;
  end

  // alarm values carry no reset and take writes whatever the lock says
  always_ff @(posedge mclk)
  begin
    alarm_q.dom <= cca_pkg::CCA_ZERO;
    alarm_q.mon <= cca_pkg::CCA_ZERO;
    alarm_q.yr  <= cca_pkg::CCA_ZERO;
    alarm_q.cen <= cca_pkg::CCA_ZERO;
    if (io_wr)
    begin
      if (io_addr == cca_pkg::CCA_ADDR_ASEC)
      begin
        alarm_q.sec <= io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_AMIN)
      begin
        alarm_q.min <= io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_AHRS)
      begin
        alarm_q.hrs <= io_wdata;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_ADOW)
      begin
        alarm_q.dow <= {cca_pkg::CCA_NIB_ZERO, io_wdata[3:0]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aen_q <= cca_pkg::CCA_AEN_RESET;
    end
    else if (io_wr && (io_addr == cca_pkg::CCA_ADDR_AEN))
    begin
      aen_q <= {cca_pkg::CCA_NIB_ZERO, io_wdata[3:0]};
    end
  end

  // control bits other than the flag; flag and reserved fields keep their reset zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= cca_pkg::CCA_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_q.alarm_irq_enable      <= io_wdata[6];
      ctrl_q.decimal_format_enable <= io_wdata[5];
      ctrl_q.count_source_select   <= io_wdata[4];
      ctrl_q.line_freq_60          <= io_wdata[3];
      ctrl_q.count_write_unlock    <= io_wdata[0];
    end
  end

  // compare one cycle after the count moved, on settled values
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmp_pend_q <= 1'b0;
    end
    else
    begin
      cmp_pend_q <= (tick && !unlocked) || cmp_force;
    end
  end

  // no enabled field means no alarm, rather than one every second
  assign any_en    = aen_q.sec || aen_q.min || aen_q.hrs || aen_q.dow;
  assign match_hit = cmp_pend_q && any_en
                     && (!aen_q.sec || (time_q.sec == alarm_q.sec))
                     && (!aen_q.min || (time_q.min == alarm_q.min))
                     && (!aen_q.hrs || (time_q.hrs == alarm_q.hrs))
                     && (!aen_q.dow || (time_q.dow[3:0] == alarm_q.dow[3:0]));

  // a new match in the clearing cycle keeps the flag set
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
    end
    else if (match_hit)
    begin
      flag_q <= 1'b1;
    end
    else if (rd_ctrl)
    begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= flag_q && ctrl_q.alarm_irq_enable;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= cca_pkg::CCA_ZERO;
    end
    else if (io_rd)
    begin
      if (io_addr == cca_pkg::CCA_ADDR_SEC)
      begin
        rdata_q <= time_q.sec;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_MIN)
      begin
        rdata_q <= time_q.min;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_HRS)
      begin
        rdata_q <= time_q.hrs;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_DOW)
      begin
        rdata_q <= {cca_pkg::CCA_NIB_ZERO, time_q.dow[3:0]};
      end
      else if (io_addr == cca_pkg::CCA_ADDR_DOM)
      begin
        rdata_q <= time_q.dom;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_MON)
      begin
        rdata_q <= time_q.mon;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_YR)
      begin
        rdata_q <= time_q.yr;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_CEN)
      begin
        rdata_q <= time_q.cen;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_ASEC)
      begin
        rdata_q <= alarm_q.sec;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_AMIN)
      begin
        rdata_q <= alarm_q.min;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_AHRS)
      begin
        rdata_q <= alarm_q.hrs;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_ADOW)
      begin
        rdata_q <= alarm_q.dow;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_AEN)
      begin
        rdata_q <= aen_q;
      end
      else if (io_addr == cca_pkg::CCA_ADDR_CTRL)
      begin
        rdata_q <= {flag_q, ctrl_q[6:0]};
      end
      else
      begin
        rdata_q <= cca_pkg::CCA_ZERO;
      end
    end
  end

  assign io_rdata = rdata_q;
  assign irq      = irq_q;

endmodule // cca_top
`default_nettype wire

// ==== cca_cpu_bfm.sv ====
// cca_cpu_bfm: cpu side of the i/o bus, one-cycle read and write strobes.
// assumes the bench calls its tasks; drives on the falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module cca_cpu_bfm
(
  input  wire logic        mclk,
  input  wire logic [7:0]  io_rdata,
  output var  logic [15:0] io_addr,
  output var  logic        io_wr,
  output var  logic        io_rd,
  output var  logic [7:0]  io_wdata
);
  initial
  begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge mclk);
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge mclk);
    d       = io_rdata;
    io_rd   = 1'b0;
    io_addr = ~a;
  endtask
endmodule // cca_cpu_bfm
`default_nettype wire

// ==== cca_top_chk.sv ====
// cca_top_chk: port-level assertions for the calendar clock.
// assumes binding to cca_top; shadows control writes to know format and irq enable.
`timescale 1ns/1ps
`default_nettype none
module cca_top_chk
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        osc32k_pin,
  input wire logic        crystal_out_pin,
  input wire logic        irq
);
  logic [7:0] ctrl_q;
  wire r_ctrl = io_rd && (io_addr == cca_pkg::CCA_ADDR_CTRL);
  wire r_sec  = io_rd && (io_addr == cca_pkg::CCA_ADDR_SEC);
  wire r_min  = io_rd && (io_addr == cca_pkg::CCA_ADDR_MIN);
  wire r_hrs  = io_rd && (io_addr == cca_pkg::CCA_ADDR_HRS);
  wire r_dow  = io_rd && (io_addr == cca_pkg::CCA_ADDR_DOW);
  wire r_mon  = io_rd && (io_addr == cca_pkg::CCA_ADDR_MON);
  // flag bit and reserved bits are not kept in the shadow
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_q <= 8'h00;
    else if (io_wr && (io_addr == cca_pkg::CCA_ADDR_CTRL))
      ctrl_q <= io_wdata & 8'h79;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ctrl_rd_back: assert property (r_ctrl |=> io_rdata[6:0] == {ctrl_q[6:3], 2'b00, ctrl_q[0]})
    else $error("control read differs from settings");
  a_irq_read_clr: assert property (r_ctrl |-> ##2 !irq)
    else $error("irq stays after control read");
  a_irq_needs_en: assert property (irq |-> $past(ctrl_q[6]))
    else $error("irq without irq enable");
  a_dow_upper_zero: assert property (r_dow |=> io_rdata[7:4] == 4'h0)
    else $error("weekday upper bits set");
  a_bin_sec_range: assert property (r_sec && !ctrl_q[5] |=> io_rdata <= 8'h3B)
    else $error("binary seconds out of range");
  a_dec_sec_digits: assert property (r_sec && ctrl_q[5] |=> io_rdata[7:4] <= 4'h5 && io_rdata[3:0] <= 4'h9)
    else $error("decimal seconds digit out of range");
  a_dec_min_digits: assert property (r_min && ctrl_q[5] |=> io_rdata[7:4] <= 4'h5 && io_rdata[3:0] <= 4'h9)
    else $error("decimal minutes digit out of range");
  a_dec_hrs_tens: assert property (r_hrs && ctrl_q[5] |=> io_rdata[7:4] <= 4'h2)
    else $error("decimal hours tens out of range");
  a_bin_mon_range: assert property (r_mon && !ctrl_q[5] |=> io_rdata inside {[8'h01:8'h0C]})
    else $error("binary month out of range");
  c_flag_read: cover property (r_ctrl ##1 io_rdata[7]);
  c_irq_rise: cover property ($rose(irq));
  c_dec_sec: cover property (r_sec && ctrl_q[5]);
endmodule // cca_top_chk
bind cca_top cca_top_chk u_chk
(
  .mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .osc32k_pin(osc32k_pin), .crystal_out_pin(crystal_out_pin), .irq(irq)
);
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for the calendar clock, line source at 50/60 Hz.
// assumes cca_cpu_bfm on the bus; oscillator pin follows the line pulses, a full 32768-edge second runs too long.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, got, exp); end end
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        line = 1'b0;
  logic        osc = 1'b0;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        irq;
  int          err_count = 0;
  int          checks_done = 0;
  logic [31:0] seed_q = 32'h0001_3785;
  cca_pkg::cca_time_s t;
  int          v;
  always #4 mclk = ~mclk;
  cca_cpu_bfm cpu (.mclk(mclk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));
  cca_top dut (.mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .osc32k_pin(osc), .crystal_out_pin(line), .irq(irq));
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction
  function automatic logic [7:0] enc(input int n, input logic dec);
    return dec ? 8'(((n / 10) << 4) + (n % 10)) : 8'(n);
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // each pulse is one rising edge of the line input; settle covers sync and update
  task automatic pulse(input int n);
    repeat (n)
    begin
      line = 1'b1;
      osc  = 1'b1;
      idle(4);
      line = 1'b0;
      osc  = 1'b0;
      idle(4);
    end
    idle(10);
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wr_time(input cca_pkg::cca_time_s tv);
    for (int i = 0; i < 8; i++)
      cpu.wr(cca_pkg::CCA_ADDR_SEC + 16'(i), tv[i*8 +: 8]);
  endtask
  task automatic chk_time(input cca_pkg::cca_time_s tv);
    for (int i = 0; i < 8; i++)
      chk_rd(cca_pkg::CCA_ADDR_SEC + 16'(i), tv[i*8 +: 8]);
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100us;
    err_count++;
    results();
  end
  initial
  begin
    idle(8);
    rst = 1'b0;
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h00);
    chk_rd(cca_pkg::CCA_ADDR_AEN, 8'h00);
    chk_rd(16'h00F0, 8'h00);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h11);
    t = '{cen:8'h13, yr:8'h04, mon:8'h02, dom:8'h1C, dow:8'h07, hrs:8'h17, min:8'h3B, sec:8'h3B};
    wr_time(t);
    pulse(50);
    chk_time(t);
    cpu.wr(cca_pkg::CCA_ADDR_ASEC, 8'h00);
    cpu.wr(cca_pkg::CCA_ADDR_AEN, 8'h01);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h10);
    pulse(50);
    chk_time('{cen:8'h13, yr:8'h04, mon:8'h03, dom:8'h01, dow:8'h01, hrs:8'h00, min:8'h00, sec:8'h00});
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h90);
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h10);
    cpu.wr(cca_pkg::CCA_ADDR_SEC, 8'h22);
    chk_rd(cca_pkg::CCA_ADDR_SEC, 8'h00);
    pulse(30);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h10);
    pulse(30);
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h90);
    chk_rd(cca_pkg::CCA_ADDR_SEC, 8'h00);
    pulse(20);
    chk_rd(cca_pkg::CCA_ADDR_SEC, 8'h01);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h18);
    pulse(50);
    chk_rd(cca_pkg::CCA_ADDR_SEC, 8'h01);
    pulse(10);
    chk_rd(cca_pkg::CCA_ADDR_SEC, 8'h02);
    cpu.wr(cca_pkg::CCA_ADDR_ASEC, 8'h02);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h58);
    idle(4);
    `CHK(irq, 1'b1)
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'hD8);
    idle(2);
    `CHK(irq, 1'b0)
    cpu.wr(cca_pkg::CCA_ADDR_AMIN, 8'h05);
    cpu.wr(cca_pkg::CCA_ADDR_AEN, 8'h03);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h58);
    idle(4);
    `CHK(irq, 1'b0)
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h58);
    chk_rd(cca_pkg::CCA_ADDR_AMIN, 8'h05);
    cpu.wr(cca_pkg::CCA_ADDR_AEN, 8'h00);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h31);
    repeat (8)
    begin
      v = int'(xs() % 32'h0000_003C);
      cpu.wr(cca_pkg::CCA_ADDR_MIN, enc(v, 1'b1));
      chk_rd(cca_pkg::CCA_ADDR_MIN, enc(v, 1'b1));
    end
    t = '{cen:enc(20, 1'b1), yr:enc(4, 1'b1), mon:enc(2, 1'b1), dom:enc(28, 1'b1), dow:8'h03,
      hrs:enc(23, 1'b1), min:enc(59, 1'b1), sec:enc(59, 1'b1)};
    wr_time(t);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h30);
    pulse(50);
    t.sec = enc(0, 1'b1);
    t.min = enc(0, 1'b1);
    t.hrs = enc(0, 1'b1);
    t.dow = 8'h04;
    t.dom = enc(29, 1'b1);
    chk_time(t);
    cpu.wr(cca_pkg::CCA_ADDR_CTRL, 8'h01);
    repeat (8)
    begin
      v = int'(xs() % 32'h0000_003C);
      cpu.wr(cca_pkg::CCA_ADDR_SEC, enc(v, 1'b0));
      chk_rd(cca_pkg::CCA_ADDR_SEC, enc(v, 1'b0));
    end
    rst = 1'b1;
    idle(8);
    rst = 1'b0;
    chk_rd(cca_pkg::CCA_ADDR_SEC, enc(v, 1'b0));
    chk_rd(cca_pkg::CCA_ADDR_CTRL, 8'h00);
    chk_rd(cca_pkg::CCA_ADDR_AEN, 8'h00);
    pulse(60);
    chk_rd(cca_pkg::CCA_ADDR_SEC, enc(v, 1'b0));
    results();
  end
endmodule // tb_top
`default_nettype wire
